// ===== rtl/adcas_defs.vh
`ifndef ADCAS_DEFS_VH
`define ADCAS_DEFS_VH

// Register word indices on the Avalon word address.
`define ADCAS_OFS_CTRL       8'hD7
`define ADCAS_OFS_SCAN       8'hE7
`define ADCAS_OFS_IRQ_EN     8'hD8
`define ADCAS_OFS_RES_HI     8'hD0
`define ADCAS_OFS_RES_LO_HI5 5'h19

// Control and status field positions.
`define ADCAS_BIT_PRESC_HI   7
`define ADCAS_BIT_PRESC_LO   6
`define ADCAS_BIT_RSVD       5
`define ADCAS_BIT_FLAG       4
`define ADCAS_BIT_START      3
`define ADCAS_BIT_CONT       2
`define ADCAS_BIT_RISE       1
`define ADCAS_BIT_FALL       0
`define ADCAS_BIT_IRQ_EN     0

// Reset values.
`define ADCAS_RST_CTRL       8'h00
`define ADCAS_RST_SCAN       8'h00
`define ADCAS_RST_IRQ_EN     1'b0

// Sample count in converter clock ticks, result width and first trial code.
`define ADCAS_SAMPLE_TICKS   2'h2
`define ADCAS_RES_BITS       10
`define ADCAS_SAR_MSB        10'h200

`endif

// ===== rtl/adcas_edge_detect.v
`timescale 1ns/1ps
module adcas_edge_detect (
  input  wire clock,
  input  wire rst_n,
  input  wire pin,
  output wire rise,
  output wire fall
);

  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  // Only the second stage and its delayed copy feed the edge logic.
  always @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

endmodule

// ===== rtl/adcas_prescaler.v
`timescale 1ns/1ps
module adcas_prescaler (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       run,
  input  wire [1:0] sel,
  output reg        tick
);

  reg  [2:0] cnt_q;
  wire [2:0] limit;

  // Division by m = 2 * (sel + 1) gives a limit of m - 1.
  assign limit = {sel, 1'b1};

  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 3'h0;
      tick  <= 1'b0;
    end else if (cnt_q == limit) begin
      cnt_q <= 3'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// ===== rtl/adcas_top.v
`timescale 1ns/1ps
`include "adcas_defs.vh"
module adcas_top (
  input  wire       clock,
  input  wire       rst_n,
  input  wire [7:0] avs_address,
  input  wire       avs_read,
  input  wire       avs_write,
  input  wire [7:0] avs_writedata,
  output reg  [7:0] avs_readdata,
  output reg        avs_waitrequest,
  input  wire       external_start_pin,
  input  wire       comparator_in,
  output reg  [2:0] analog_channel_n_q,
  output reg        sample_hold_q,
  output reg  [9:0] dac_code_q,
  output reg        capture_pulse_q,
  output reg        irq_q
);

  localparam [4:0] ST_IDLE    = 5'h01;
  localparam [4:0] ST_SETTLE  = 5'h02;
  localparam [4:0] ST_SAMPLE  = 5'h04;
  localparam [4:0] ST_CONVERT = 5'h08;
  localparam [4:0] ST_STORE   = 5'h10;

  // Reset image of the control register; each field takes its own slice of it.
  localparam [7:0] CTRL_RST   = `ADCAS_RST_CTRL;

  // Returns {found, index} of the lowest set bit at or above the given position.
  function [3:0] adcas_pick;
    input [7:0] set;
    input [3:0] from;
    integer     i;
    reg   [3:0] r;
    begin
      r = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (set[i] && (i >= from)) begin
          r = {1'b1, i[2:0]};
        end
      end
      adcas_pick = r;
    end
  endfunction

  reg  [1:0] prescale_sel_q;
  reg        continuous_scan_sel_q;
  reg        rise_edge_start_en_q;
  reg        fall_edge_start_en_q;
  reg        scan_complete_flag_q;
  reg        start_status_bit_q;
  reg        start_pend_q;
  reg        irq_en_q;
  reg  [7:0] scan_select_q;
  reg  [7:0] active_set_q;
  reg  [4:0] state_q;
  reg  [1:0] cnt_q;
  reg  [9:0] mask_q;
  reg  [1:0] hi_latch_q;
  reg  [1:0] hi_shadow_q;
  reg  [9:0] result_mem [0:7];
  reg  [7:0] rd_data;
  reg  [9:0] code_v;

  wire       tick;
  wire       pin_rise;
  wire       pin_fall;
  wire       acc;
  wire       wr_acc;
  wire       rd_acc;
  wire       rd_load;
  wire       sel_ctrl;
  wire       sel_scan;
  wire       sel_irq_en;
  wire       sel_res_hi;
  wire       sel_res_lo;
  wire       ctrl_wr;
  wire       edge_start;
  wire       sw_start;
  wire       start_req;
  wire       sw_abort;
  wire       launch;
  wire [3:0] first_new;
  wire [3:0] next_ch;
  wire       in_store;
  wire       loop_done;
  wire       restart;

  adcas_prescaler adcas_prescaler_inst (
    .clock (clock),
    .rst_n (rst_n),
    .run   (state_q != ST_IDLE),
    .sel   (prescale_sel_q),
    .tick  (tick)
  );

  adcas_edge_detect adcas_edge_detect_inst (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (external_start_pin),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // One wait state: the request is seen, then accepted while waitrequest is low.
  assign acc        = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_acc     = acc & avs_write;
  assign rd_acc     = acc & avs_read;
  assign rd_load    = (avs_read | avs_write) & avs_waitrequest;
  assign sel_ctrl   = (avs_address == `ADCAS_OFS_CTRL);
  assign sel_scan   = (avs_address == `ADCAS_OFS_SCAN);
  assign sel_irq_en = (avs_address == `ADCAS_OFS_IRQ_EN);
  assign sel_res_hi = (avs_address == `ADCAS_OFS_RES_HI);
  assign sel_res_lo = (avs_address[7:3] == `ADCAS_OFS_RES_LO_HI5);
  assign ctrl_wr    = wr_acc & sel_ctrl;

  assign edge_start = (pin_rise & rise_edge_start_en_q) | (pin_fall & fall_edge_start_en_q);
  assign sw_start   = ctrl_wr & avs_writedata[`ADCAS_BIT_START];
  assign start_req  = (sw_start | edge_start) & ~start_status_bit_q;
  assign sw_abort   = ctrl_wr & ~avs_writedata[`ADCAS_BIT_START] & start_status_bit_q;

  // A held-off start waits for the flag to clear; an empty selection blocks it.
  assign launch = (start_req | start_pend_q) & ~scan_complete_flag_q &
                  ~start_status_bit_q & (scan_select_q != 8'h00);

  assign first_new = adcas_pick(scan_select_q, 4'h0);
  assign next_ch   = adcas_pick(active_set_q, {1'b0, analog_channel_n_q} + 4'h1);
  assign in_store  = (state_q == ST_STORE);
  assign loop_done = in_store & ~next_ch[3];
  assign restart   = loop_done & continuous_scan_sel_q & first_new[3];

  always @* begin
    rd_data = 8'h00;
    if (sel_ctrl) begin
      rd_data = {prescale_sel_q, 1'b0, scan_complete_flag_q, start_status_bit_q,
                 continuous_scan_sel_q, rise_edge_start_en_q, fall_edge_start_en_q};
    end else if (sel_scan) begin
      rd_data = scan_select_q;
    end else if (sel_irq_en) begin
      rd_data = {7'h00, irq_en_q};
    end else if (sel_res_hi) begin
      rd_data = {6'h00, hi_latch_q};
    end else if (sel_res_lo) begin
      rd_data = result_mem[avs_address[2:0]][7:0];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 8'h00;
    end else if (acc) begin
      avs_waitrequest <= 1'b1;
    end else if (rd_load) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_data;
    end
  end

  // Control bits; the reserved bit is not stored and always reads zero.
  always @(posedge clock) begin
    if (!rst_n) begin
      prescale_sel_q        <= CTRL_RST[`ADCAS_BIT_PRESC_HI:`ADCAS_BIT_PRESC_LO];
      continuous_scan_sel_q <= CTRL_RST[`ADCAS_BIT_CONT];
      rise_edge_start_en_q  <= CTRL_RST[`ADCAS_BIT_RISE];
      fall_edge_start_en_q  <= CTRL_RST[`ADCAS_BIT_FALL];
      scan_select_q         <= `ADCAS_RST_SCAN;
      irq_en_q              <= `ADCAS_RST_IRQ_EN;
    end else if (wr_acc) begin
      if (sel_ctrl) begin
        prescale_sel_q        <= avs_writedata[`ADCAS_BIT_PRESC_HI:`ADCAS_BIT_PRESC_LO];
        continuous_scan_sel_q <= avs_writedata[`ADCAS_BIT_CONT];
        rise_edge_start_en_q  <= avs_writedata[`ADCAS_BIT_RISE];
        fall_edge_start_en_q  <= avs_writedata[`ADCAS_BIT_FALL];
      end
      if (sel_scan) begin
        scan_select_q <= avs_writedata;
      end
      if (sel_irq_en) begin
        irq_en_q <= avs_writedata[`ADCAS_BIT_IRQ_EN];
      end
    end
  end

  // Flag, start/status, held-off start, capture and interrupt.
  always @(posedge clock) begin
    if (!rst_n) begin
      scan_complete_flag_q <= 1'b0;
      start_status_bit_q   <= 1'b0;
      start_pend_q         <= 1'b0;
      capture_pulse_q      <= 1'b0;
      irq_q                <= 1'b0;
    end else begin
      // Setting wins over a simultaneous software clear so no loop end is lost.
      if (loop_done) begin
        scan_complete_flag_q <= 1'b1;
      end else if (ctrl_wr && !avs_writedata[`ADCAS_BIT_FLAG]) begin
        scan_complete_flag_q <= 1'b0;
      end
      if (launch) begin
        start_status_bit_q <= 1'b1;
      end else if (sw_abort) begin
        start_status_bit_q <= 1'b0;
      end else if (loop_done && !restart) begin
        start_status_bit_q <= 1'b0;
      end
      if (launch) begin
        start_pend_q <= 1'b0;
      end else if (ctrl_wr && !avs_writedata[`ADCAS_BIT_START]) begin
        start_pend_q <= 1'b0;
      end else if (start_req) begin
        start_pend_q <= 1'b1;
      end
      capture_pulse_q <= edge_start;
      irq_q           <= scan_complete_flag_q & irq_en_q;
    end
  end

  always @* begin
    code_v = dac_code_q;
    if (!comparator_in) begin
      code_v = dac_code_q & ~mask_q;
    end
  end

  // Scan sequencer: settle, sample for two ticks, ten bit trials, store.
  always @(posedge clock) begin
    if (!rst_n) begin
      state_q            <= ST_IDLE;
      active_set_q       <= 8'h00;
      analog_channel_n_q <= 3'h0;
      cnt_q              <= 2'h0;
      mask_q             <= 10'h000;
      dac_code_q         <= 10'h000;
      sample_hold_q      <= 1'b0;
    end else if (sw_abort) begin
      state_q       <= ST_IDLE;
      sample_hold_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            active_set_q       <= scan_select_q;
            analog_channel_n_q <= first_new[2:0];
            state_q            <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (tick) begin
            state_q       <= ST_SAMPLE;
            sample_hold_q <= 1'b1;
            cnt_q         <= 2'h0;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (cnt_q == `ADCAS_SAMPLE_TICKS - 2'h1) begin
              state_q       <= ST_CONVERT;
              sample_hold_q <= 1'b0;
              mask_q        <= `ADCAS_SAR_MSB;
              dac_code_q    <= `ADCAS_SAR_MSB;
            end else begin
              cnt_q <= cnt_q + 2'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            if (mask_q[0]) begin
              dac_code_q <= code_v;
              state_q    <= ST_STORE;
            end else begin
              dac_code_q <= code_v | (mask_q >> 1);
              mask_q     <= mask_q >> 1;
            end
          end
        end
        ST_STORE: begin
          if (next_ch[3]) begin
            analog_channel_n_q <= next_ch[2:0];
            state_q            <= ST_SETTLE;
          end else if (restart) begin
            active_set_q       <= scan_select_q;
            analog_channel_n_q <= first_new[2:0];
            state_q            <= ST_SETTLE;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Results and the high-bit latch are kept through reset on purpose.
  always @(posedge clock) begin
    if (in_store) begin
      result_mem[analog_channel_n_q] <= dac_code_q;
    end
    // Upper bits are taken with the low byte, so a store in between cannot split a pair.
    if (rd_load && avs_read && sel_res_lo) begin
      hi_shadow_q <= result_mem[avs_address[2:0]][9:8];
    end
    if (rd_acc && sel_res_lo) begin
      hi_latch_q <= hi_shadow_q;
    end
  end

endmodule

// ===== verif/adcas_analog_model.sv
`timescale 1ns/1ps
module adcas_analog_model (
  input  wire [79:0] levels,
  input  wire [2:0]  analog_channel_n_q,
  input  wire [9:0]  dac_code_q,
  output logic       comparator_in
);
  // Ideal comparator, so the expected result of a channel equals its level exactly.
  always_comb comparator_in = levels[analog_channel_n_q * 10 +: 10] >= dac_code_q;
endmodule

// ===== verif/adcas_top_sva.sv
`timescale 1ns/1ps
`include "adcas_defs.vh"
module adcas_top_sva (
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] avs_address,
  input wire       avs_read,
  input wire       avs_write,
  input wire [7:0] avs_writedata,
  input wire [7:0] avs_readdata,
  input wire       avs_waitrequest,
  input wire       external_start_pin,
  input wire       comparator_in,
  input wire [2:0] analog_channel_n_q,
  input wire       sample_hold_q,
  input wire [9:0] dac_code_q,
  input wire       capture_pulse_q,
  input wire       irq_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rd_ok = avs_read && !avs_waitrequest;
  wire ctrl_acc = avs_write && !avs_waitrequest && avs_address == `ADCAS_OFS_CTRL;
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_high_zero: assert property (rd_ok && avs_address == `ADCAS_OFS_RES_HI |->
    avs_readdata[7:2] == 6'h00) else $error("high result upper bits not zero");
  a_rsvd_zero: assert property (rd_ok && avs_address == `ADCAS_OFS_CTRL |->
    !avs_readdata[5]) else $error("reserved control bit reads one");
  a_unmapped_zero: assert property (rd_ok && avs_address < 8'hC8 |-> avs_readdata == 8'h00)
    else $error("unmapped read not zero");
  a_sample_min: assert property (disable iff (!rst_n || ctrl_acc)
    $rose(sample_hold_q) |-> sample_hold_q [*4])
    else $error("sample window shorter than two ticks");
  a_sample_max: assert property (disable iff (!rst_n || ctrl_acc)
    $rose(sample_hold_q) |-> ##[4:17] !sample_hold_q)
    else $error("sample window longer than two ticks");
  a_chan_hold: assert property (sample_hold_q && $past(sample_hold_q) |->
    $stable(analog_channel_n_q)) else $error("channel changed while sampling");
  a_capture_edge: assert property (capture_pulse_q |->
    $past(external_start_pin, 3) != $past(external_start_pin, 4))
    else $error("capture pulse without synchronised pin edge");
  cover property ($rose(irq_q));
  cover property (capture_pulse_q);
  cover property ($rose(sample_hold_q));
endmodule

// ===== verif/test_adc_autoscan_control.sv
`timescale 1ns/1ps
`include "adcas_defs.vh"
module test_adc_autoscan_control;
  logic        clock;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [7:0]  avs_writedata;
  wire  [7:0]  avs_readdata;
  wire         avs_waitrequest;
  logic        external_start_pin;
  wire         comparator_in;
  wire  [2:0]  analog_channel_n_q;
  wire         sample_hold_q;
  wire  [9:0]  dac_code_q;
  wire         capture_pulse_q;
  wire         irq_q;
  logic [79:0] levels;
  logic [7:0]  rd;
  logic [7:0]  sel;
  int          err_count;
  int          checked;
  int          cycles;
  int          captures;
  int          samples;
  int          base;

  adcas_top adcas_top_inst (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_start_pin(external_start_pin), .comparator_in(comparator_in),
    .analog_channel_n_q(analog_channel_n_q), .sample_hold_q(sample_hold_q),
    .dac_code_q(dac_code_q), .capture_pulse_q(capture_pulse_q), .irq_q(irq_q));
  adcas_analog_model adcas_analog_model_inst (.levels(levels),
    .analog_channel_n_q(analog_channel_n_q), .dac_code_q(dac_code_q),
    .comparator_in(comparator_in));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (capture_pulse_q === 1'b1) captures <= captures + 1;
    if (sample_hold_q === 1'b1) samples <= samples + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Each channel samples for two ticks of m = 2 * (p + 1) clocks.
  function automatic int exp_samples(input logic [7:0] s, input logic [1:0] p);
    int c;
    c = 0;
    for (int i = 0; i < 8; i++) c += s[i];
    return c * 4 * (int'(p) + 1);
  endfunction

  task automatic complete_run;
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // A spare edge after each release keeps two requests out of one time step.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_irq;
    while (irq_q !== 1'b1) @(posedge clock);
  endtask

  task automatic scan_once(input logic [1:0] p);
    sel = 8'($urandom);
    if (sel == 8'h00) sel = 8'h80;
    bus_wr(`ADCAS_OFS_SCAN, sel);
    base = samples;
    bus_wr(`ADCAS_OFS_CTRL, {p, 6'h08});
    wait_irq();
    check("sample cycles", 10'(samples - base), 10'(exp_samples(sel, p)));
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("ctrl after scan", rd, {p, 6'h10});
    bus_wr(`ADCAS_OFS_CTRL, {p, 6'h18});
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("held start", rd, {p, 6'h10});
    for (int n = 0; n < 8; n++) begin
      if (sel[n]) begin
        bus_rd(8'(8'hC8 + n), rd);
        check("low byte", rd, levels[n * 10 +: 8]);
        bus_rd(`ADCAS_OFS_RES_HI, rd);
        check("high bits", rd, {6'h00, levels[n * 10 + 8 +: 2]});
      end
    end
    bus_wr(`ADCAS_OFS_CTRL, {p, 6'h00});
    repeat (2) @(posedge clock);
    check("irq cleared", irq_q, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 8'h00;
    external_start_pin = 1'b0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    captures = 0;
    samples = 0;
    base = 0;
    rd = 8'($urandom(83313));
    for (int i = 0; i < 8; i++) levels[i * 10 +: 10] = 10'($urandom);
    levels[9:0] = 10'h3FF;
    levels[19:10] = 10'h000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("ctrl reset", rd, 8'h00);
    bus_rd(`ADCAS_OFS_SCAN, rd);
    check("scan reset", rd, 8'h00);
    bus_rd(8'h10, rd);
    check("unmapped", rd, 8'h00);
    bus_wr(`ADCAS_OFS_CTRL, 8'h08);
    repeat (40) @(posedge clock);
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("empty selection", rd, 8'h00);
    check("no sampling", sample_hold_q, 1'b0);
    bus_wr(`ADCAS_OFS_CTRL, 8'h00);
    bus_wr(`ADCAS_OFS_IRQ_EN, 8'h01);
    for (int p = 0; p < 4; p++) scan_once(2'(p));
    bus_wr(`ADCAS_OFS_SCAN, 8'h81);
    bus_wr(`ADCAS_OFS_CTRL, 8'h06);
    external_start_pin <= 1'b1;
    repeat (6) @(posedge clock);
    check("rise capture", 10'(captures), 10'h001);
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("pin start", rd, 8'h0E);
    wait_irq();
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("continuous status", rd, 8'h1E);
    external_start_pin <= 1'b0;
    repeat (6) @(posedge clock);
    check("fall ignored", 10'(captures), 10'h001);
    bus_wr(`ADCAS_OFS_CTRL, 8'h06);
    repeat (400) @(posedge clock);
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("abort", rd, 8'h06);
    bus_wr(`ADCAS_OFS_CTRL, 8'h05);
    external_start_pin <= 1'b1;
    repeat (6) @(posedge clock);
    check("rise ignored", 10'(captures), 10'h001);
    external_start_pin <= 1'b0;
    repeat (6) @(posedge clock);
    check("fall capture", 10'(captures), 10'h002);
    bus_rd(`ADCAS_OFS_CTRL, rd);
    check("fall start", rd, 8'h0D);
    bus_wr(`ADCAS_OFS_CTRL, 8'h00);
    complete_run();
  end
endmodule

bind adcas_top adcas_top_sva adcas_top_sva_inst (.clock(clock), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .external_start_pin(external_start_pin),
  .comparator_in(comparator_in), .analog_channel_n_q(analog_channel_n_q),
  .sample_hold_q(sample_hold_q), .dac_code_q(dac_code_q),
  .capture_pulse_q(capture_pulse_q), .irq_q(irq_q));
